// ### src/aoc_map.vh
// Purpose: Register map, field positions and reset values of the alarm output controller
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes: Definitions only
`ifndef AOC_MAP_VH
`define AOC_MAP_VH

// Byte offsets
`define AOC_ADDR_W 8
`define AOC_OFF_CTRL 8'h00
`define AOC_OFF_CMD 8'h04
`define AOC_OFF_STAT 8'h08
`define AOC_OFF_ASSIGN 8'h0C
`define AOC_OFF_QUERY 8'h10
`define AOC_OFF_IRQ_STAT 8'h14
`define AOC_OFF_IRQ_MASK 8'h18

// Decoded register selects
`define AOC_SEL_CTRL 3'h0
`define AOC_SEL_CMD 3'h1
`define AOC_SEL_STAT 3'h2
`define AOC_SEL_ASSIGN 3'h3
`define AOC_SEL_QUERY 3'h4
`define AOC_SEL_IRQ_STAT 3'h5
`define AOC_SEL_IRQ_MASK 3'h6
`define AOC_SEL_NONE 3'h7

// Control: mode bits (1 = latch, 0 = track), polarity bits (1 = active high)
`define AOC_CTRL_MODE_LSB 0
`define AOC_CTRL_POL_LSB 4
`define AOC_CTRL_RST 8'hF0
// Command: per-line manual clear bits 3:0, scan start bit
`define AOC_CMD_SCAN_BIT 4
// Status: seen bits and init busy
`define AOC_STAT_SEEN_LSB 4
`define AOC_STAT_BUSY_BIT 8
// Assignment and query fields
`define AOC_ASG_LINE_LSB 8
`define AOC_ASG_EN_BIT 16
`define AOC_QRY_DONE_BIT 31
// Assignment entry {enable, line[1:0]}
`define AOC_ENT_W 3
`define AOC_ENT_EN_BIT 2
`define AOC_ENT_DEFAULT 3'h4
// Interrupt mask reset
`define AOC_MASK_RST 4'h0
// AXI responses
`define AOC_RESP_OKAY 2'h0
`define AOC_RESP_SLVERR 2'h2

`endif

// ### src/aoc_assign_mem.v
// Purpose: Channel to alarm line assignment memory
// Assumes: One write port, one read port, same clock
// Notes: Read data registered, one cycle after rd_en_in; no reset on contents
module aoc_assign_mem #(
   parameter AW = 8,
   parameter DW = 3
) (
   input wire clock_in, // System clock
   input wire wr_en_in, // Write strobe
   input wire [AW-1:0] wr_addr_in, // Write index
   input wire [DW-1:0] wr_data_in, // Write word
   input wire rd_en_in, // Read strobe
   input wire [AW-1:0] rd_addr_in, // Read index
   output reg [DW-1:0] rd_data_out // Registered read word
);
   reg [DW-1:0] mem_q [0:(1<<AW)-1];

   // Write port
   always @(posedge clock_in) begin
      if (wr_en_in) begin
         mem_q[wr_addr_in] <= wr_data_in;
      end
   end

   // Registered read keeps the lookup off the output path
   always @(posedge clock_in) begin
      if (rd_en_in) begin
         rd_data_out <= mem_q[rd_addr_in];
      end
   end
endmodule

// ### src/aoc_top.v
// Purpose: Four alarm output lines driven by per-channel alarm readings
// Assumes: Reading, scan and scanning inputs come from logic on clock_in
// Notes: Registers over AXI4-Lite; one level interrupt
`include "aoc_map.vh"
module aoc_top #(
   parameter CH_W = 8,
   parameter CNT_W = 9
) (
   input wire clock_in, // System clock, 10 MHz
   input wire rst_n_in, // Synchronous reset, active low
   input wire [7:0] s_axi_awaddr_in, // Write address
   input wire s_axi_awvalid_in, // Write address valid
   output reg s_axi_awready_out, // Write address ready
   input wire [31:0] s_axi_wdata_in, // Write data
   input wire [3:0] s_axi_wstrb_in, // Write byte strobes
   input wire s_axi_wvalid_in, // Write data valid
   output reg s_axi_wready_out, // Write data ready
   output reg [1:0] s_axi_bresp_out, // Write response
   output reg s_axi_bvalid_out, // Write response valid
   input wire s_axi_bready_in, // Write response ready
   input wire [7:0] s_axi_araddr_in, // Read address
   input wire s_axi_arvalid_in, // Read address valid
   output reg s_axi_arready_out, // Read address ready
   output reg [31:0] s_axi_rdata_out, // Read data
   output reg [1:0] s_axi_rresp_out, // Read response
   output reg s_axi_rvalid_out, // Read data valid
   input wire s_axi_rready_in, // Read data ready
   input wire reading_valid_in, // One reading this cycle
   input wire [CH_W-1:0] reading_chan_in, // Channel of the reading
   input wire reading_alarm_in, // Reading meets its alarm condition
   input wire scanning_in, // Scan or monitor in progress
   input wire scan_start_in, // New scan begins, pulse
   output reg first_alarm_line_out, // Alarm pin 1
   output reg second_alarm_line_out, // Alarm pin 2
   output reg third_alarm_line_out, // Alarm pin 3
   output reg fourth_alarm_line_out, // Alarm pin 4
   output reg irq_out // Interrupt, level high
);
   localparam NL = 4;
   localparam [CH_W-1:0] LAST_CH = {CH_W{1'b1}};
   localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

   // Address decode, shared by write and read paths
   function [2:0] reg_sel;
      input [7:0] a;
      begin
         case (a)
            `AOC_OFF_CTRL: reg_sel = `AOC_SEL_CTRL;
            `AOC_OFF_CMD: reg_sel = `AOC_SEL_CMD;
            `AOC_OFF_STAT: reg_sel = `AOC_SEL_STAT;
            `AOC_OFF_ASSIGN: reg_sel = `AOC_SEL_ASSIGN;
            `AOC_OFF_QUERY: reg_sel = `AOC_SEL_QUERY;
            `AOC_OFF_IRQ_STAT: reg_sel = `AOC_SEL_IRQ_STAT;
            `AOC_OFF_IRQ_MASK: reg_sel = `AOC_SEL_IRQ_MASK;
            default: reg_sel = `AOC_SEL_NONE;
         endcase
      end
   endfunction

   reg aw_full_q;
   reg [7:0] awaddr_q;
   reg w_full_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg [7:0] ctrl_q;
   reg [3:0] mask_q;
   reg [3:0] irq_stat_q;
   reg init_busy_q;
   reg [CH_W-1:0] init_idx_q;
   reg vld_p_q;
   reg [CH_W-1:0] chan_p_q;
   reg alarm_p_q;
   reg qry_pend_q;
   reg qry_issued_q;
   reg [CH_W-1:0] qry_chan_q;
   reg [`AOC_ENT_W-1:0] qry_res_q;
   reg qry_done_q;
   reg [(1<<CH_W)-1:0] outside_q;
   wire [`AOC_ENT_W-1:0] ent;
   wire [3:0] out_v;
   wire [3:0] seen_v;
   wire [3:0] ev_v;
   wire [3:0] pin_v;

   // Write byte lanes
   wire [31:0] lane_m = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   wire [31:0] wd = wdata_q & lane_m;
   wire do_wr = aw_full_q & w_full_q & ~s_axi_bvalid_out;
   wire [2:0] wsel = reg_sel(awaddr_q);
   wire wr_cmd = do_wr & (wsel == `AOC_SEL_CMD);
   wire wr_asg = do_wr & (wsel == `AOC_SEL_ASSIGN) & ~init_busy_q;
   wire wr_qry = do_wr & (wsel == `AOC_SEL_QUERY);
   wire [3:0] man_clr = wr_cmd ? wd[3:0] : 4'h0;
   wire scan_go = scan_start_in | (wr_cmd & wd[`AOC_CMD_SCAN_BIT]);
   // Tracking counts restart when a scan starts or routing changes
   wire restart = scan_go | wr_asg;

   // Write channel handshake: address and data taken in either order
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `AOC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid_in & s_axi_awready_out) begin
            aw_full_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_in;
            s_axi_awready_out <= 1'b0;
         end else if (do_wr) begin
            aw_full_q <= 1'b0;
            s_axi_awready_out <= 1'b1;
         end else begin
            s_axi_awready_out <= ~aw_full_q;
         end
         if (s_axi_wvalid_in & s_axi_wready_out) begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata_in;
            wstrb_q <= s_axi_wstrb_in;
            s_axi_wready_out <= 1'b0;
         end else if (do_wr) begin
            w_full_q <= 1'b0;
            s_axi_wready_out <= 1'b1;
         end else begin
            s_axi_wready_out <= ~w_full_q;
         end
         if (do_wr) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (wsel == `AOC_SEL_NONE) ? `AOC_RESP_SLVERR : `AOC_RESP_OKAY;
         end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   // Control, mask and interrupt status; a new event beats a W1C
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         ctrl_q <= `AOC_CTRL_RST;
         mask_q <= `AOC_MASK_RST;
         irq_stat_q <= 4'h0;
         irq_out <= 1'b0;
      end else begin
         if (do_wr & (wsel == `AOC_SEL_CTRL)) begin
            ctrl_q <= wd[7:0];
         end
         if (do_wr & (wsel == `AOC_SEL_IRQ_MASK)) begin
            mask_q <= wd[3:0];
         end
         if (do_wr & (wsel == `AOC_SEL_IRQ_STAT)) begin
            irq_stat_q <= (irq_stat_q & ~wd[3:0]) | ev_v;
         end else begin
            irq_stat_q <= irq_stat_q | ev_v;
         end
         irq_out <= |((irq_stat_q | ev_v) & mask_q);
      end
   end

   // Read channel: answer one cycle after the address is taken
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h00000000;
         s_axi_rresp_out <= `AOC_RESP_OKAY;
      end else if (s_axi_arvalid_in & s_axi_arready_out) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b1;
         s_axi_rresp_out <= `AOC_RESP_OKAY;
         s_axi_rdata_out <= 32'h00000000;
         case (reg_sel(s_axi_araddr_in))
            `AOC_SEL_CTRL: s_axi_rdata_out[7:0] <= ctrl_q;
            `AOC_SEL_STAT: begin
               s_axi_rdata_out[3:0] <= out_v;
               s_axi_rdata_out[`AOC_STAT_SEEN_LSB+3:`AOC_STAT_SEEN_LSB] <= seen_v;
               s_axi_rdata_out[`AOC_STAT_BUSY_BIT] <= init_busy_q;
            end
            `AOC_SEL_QUERY: begin
               s_axi_rdata_out[CH_W-1:0] <= qry_chan_q;
               s_axi_rdata_out[`AOC_ASG_LINE_LSB+1:`AOC_ASG_LINE_LSB] <= qry_res_q[1:0];
               s_axi_rdata_out[`AOC_ASG_EN_BIT] <= qry_res_q[`AOC_ENT_EN_BIT];
               s_axi_rdata_out[`AOC_QRY_DONE_BIT] <= qry_done_q;
            end
            `AOC_SEL_IRQ_STAT: s_axi_rdata_out[3:0] <= irq_stat_q;
            `AOC_SEL_IRQ_MASK: s_axi_rdata_out[3:0] <= mask_q;
            `AOC_SEL_CMD: s_axi_rdata_out <= 32'h00000000;
            `AOC_SEL_ASSIGN: s_axi_rdata_out <= 32'h00000000;
            default: s_axi_rresp_out <= `AOC_RESP_SLVERR;
         endcase
      end else begin
         if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
         s_axi_arready_out <= ~s_axi_rvalid_out | s_axi_rready_in;
      end
   end

   // Default routing sweep after reset; software adds during it are dropped
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         init_busy_q <= 1'b1;
         init_idx_q <= {CH_W{1'b0}};
      end else if (init_busy_q) begin
         init_idx_q <= init_idx_q + 1'b1;
         if (init_idx_q == LAST_CH) begin
            init_busy_q <= 1'b0;
         end
      end
   end

   // Reading lookup has the read port first; queries take idle cycles
   wire rd_reading = reading_valid_in & scanning_in & ~init_busy_q;
   wire qry_go = qry_pend_q & ~rd_reading;

   aoc_assign_mem #(
      .AW(CH_W),
      .DW(`AOC_ENT_W)
   ) u_mem (
      .clock_in(clock_in),
      .wr_en_in(init_busy_q | wr_asg),
      .wr_addr_in(init_busy_q ? init_idx_q : wd[CH_W-1:0]),
      .wr_data_in(init_busy_q ? `AOC_ENT_DEFAULT :
         {wd[`AOC_ASG_EN_BIT], wd[`AOC_ASG_LINE_LSB+1:`AOC_ASG_LINE_LSB]}),
      .rd_en_in(rd_reading | qry_go),
      .rd_addr_in(rd_reading ? reading_chan_in : qry_chan_q),
      .rd_data_out(ent)
   );

   // Reading pipeline and routing query bookkeeping
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         vld_p_q <= 1'b0;
         chan_p_q <= {CH_W{1'b0}};
         alarm_p_q <= 1'b0;
         qry_pend_q <= 1'b0;
         qry_issued_q <= 1'b0;
         qry_chan_q <= {CH_W{1'b0}};
         qry_res_q <= {`AOC_ENT_W{1'b0}};
         qry_done_q <= 1'b0;
      end else begin
         vld_p_q <= rd_reading;
         chan_p_q <= reading_chan_in;
         alarm_p_q <= reading_alarm_in;
         qry_issued_q <= qry_go;
         if (wr_qry) begin
            qry_pend_q <= 1'b1;
            qry_chan_q <= wd[CH_W-1:0];
            qry_done_q <= 1'b0;
         end else if (qry_go) begin
            qry_pend_q <= 1'b0;
         end
         if (qry_issued_q & ~wr_qry) begin
            qry_res_q <= ent;
            qry_done_q <= 1'b1;
         end
      end
   end

   // Per-channel outside-limit memory so one line can OR many channels
   wire hit_any = vld_p_q & ent[`AOC_ENT_EN_BIT];
   wire was_out = outside_q[chan_p_q];
   always @(posedge clock_in) begin
      if (!rst_n_in | restart) begin
         outside_q <= {(1<<CH_W){1'b0}};
      end else if (hit_any) begin
         outside_q[chan_p_q] <= alarm_p_q;
      end
   end

   // One alarm line per iteration
   genvar i;
   generate
      for (i = 0; i < NL; i = i + 1) begin : g_line
         localparam [1:0] LN = i;
         reg out_q;
         reg seen_q;
         reg [CNT_W-1:0] cnt_q;
         wire latch_m = ctrl_q[`AOC_CTRL_MODE_LSB+i];
         wire hit = hit_any & (ent[1:0] == LN);
         wire ev = hit & alarm_p_q;
         wire rise = ev & ~was_out;
         wire fall = hit & ~alarm_p_q & was_out;
         reg out_d;

         // Output state; a fresh alarm wins over any clear
         always @* begin
            out_d = out_q;
            if (ev) begin
               out_d = 1'b1;
            end else if (man_clr[i]) begin
               out_d = 1'b0;
            end else if (scan_go) begin
               out_d = 1'b0;
            end else if (~latch_m & fall & (cnt_q == CNT_ONE)) begin
               out_d = 1'b0;
            end
         end

         // Count of channels of this line outside their limits
         always @(posedge clock_in) begin
            if (!rst_n_in | restart) begin
               cnt_q <= {CNT_W{1'b0}};
            end else if (rise) begin
               cnt_q <= cnt_q + CNT_ONE;
            end else if (fall) begin
               cnt_q <= cnt_q - CNT_ONE;
            end
         end

         // Alarm data: only a scan start erases it, never a manual clear
         always @(posedge clock_in) begin
            if (!rst_n_in) begin
               out_q <= 1'b0;
               seen_q <= 1'b0;
            end else begin
               out_q <= out_d;
               if (ev) begin
                  seen_q <= 1'b1;
               end else if (scan_go) begin
                  seen_q <= 1'b0;
               end
            end
         end

         assign out_v[i] = out_q;
         assign seen_v[i] = seen_q;
         assign ev_v[i] = ev;
         // Inactive level is the opposite of the active level
         assign pin_v[i] = ctrl_q[`AOC_CTRL_POL_LSB+i] ? out_d : ~out_d;
      end
   endgenerate

   // Pins registered; reset matches active-high default, so idle low
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         first_alarm_line_out <= 1'b0;
         second_alarm_line_out <= 1'b0;
         third_alarm_line_out <= 1'b0;
         fourth_alarm_line_out <= 1'b0;
      end else begin
         first_alarm_line_out <= pin_v[0];
         second_alarm_line_out <= pin_v[1];
         third_alarm_line_out <= pin_v[2];
         fourth_alarm_line_out <= pin_v[3];
      end
   end
endmodule

// ### tb/aoc_top_monitor.sv
// Purpose: Port checker for the alarm output controller
// Assumes: Bound to aoc_top, one clock domain
// Notes: Pin moves and irq rises need a cause a few edges back
`include "aoc_map.vh"
module aoc_top_monitor (
   input wire logic clock_in, // Clock
   input wire logic rst_n_in, // Reset
   input wire logic s_axi_awvalid_in, // Aw valid
   input wire logic s_axi_awready_out, // Aw ready
   input wire logic s_axi_wvalid_in, // W valid
   input wire logic s_axi_wready_out, // W ready
   input wire logic s_axi_bvalid_out, // B valid
   input wire logic s_axi_bready_in, // B ready
   input wire logic [7:0] s_axi_araddr_in, // Ar address
   input wire logic s_axi_arvalid_in, // Ar valid
   input wire logic s_axi_arready_out, // Ar ready
   input wire logic [31:0] s_axi_rdata_out, // R data
   input wire logic [1:0] s_axi_rresp_out, // R response
   input wire logic s_axi_rvalid_out, // R valid
   input wire logic s_axi_rready_in, // R ready
   input wire logic reading_valid_in, // Reading strobe
   input wire logic scan_start_in, // Scan start
   input wire logic first_alarm_line_out, // Pin 1
   input wire logic second_alarm_line_out, // Pin 2
   input wire logic third_alarm_line_out, // Pin 3
   input wire logic fourth_alarm_line_out, // Pin 4
   input wire logic irq_out // Interrupt
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pins gathered so one check covers all lines
   wire [3:0] pins = {fourth_alarm_line_out, third_alarm_line_out,
      second_alarm_line_out, first_alarm_line_out};
   wire rd_take = s_axi_arvalid_in && s_axi_arready_out;
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);
   chk_pin_cause: assert property ($changed(pins) |->
      $past(reading_valid_in, 2) || $past(reading_valid_in, 3) || $past(scan_start_in)
      || $past(scan_start_in, 2) || s_axi_bvalid_out || $past(s_axi_bvalid_out)
      || $past(s_axi_bvalid_out, 2)) else $error("alarm pin moved without cause");
   chk_irq_cause: assert property ($rose(irq_out) |->
      $past(reading_valid_in, 2) || $past(reading_valid_in, 3) || s_axi_bvalid_out
      || $past(s_axi_bvalid_out) || $past(s_axi_bvalid_out, 2))
      else $error("irq rose without cause");
   chk_wr_accept: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
      && s_axi_wready_out |=> !s_axi_awready_out && !s_axi_wready_out ##1 s_axi_bvalid_out)
      else $error("write not answered in time");
   chk_wr_done: assert property ($rose(s_axi_bvalid_out) |->
      s_axi_awready_out && s_axi_wready_out) else $error("write holders not freed");
   chk_b_release: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
      else $error("bvalid held after take");
   chk_rd_accept: assert property (rd_take |=> s_axi_rvalid_out && !s_axi_arready_out)
      else $error("read not answered next cycle");
   chk_rd_release: assert property (s_axi_rvalid_out && s_axi_rready_in |=>
      !s_axi_rvalid_out && s_axi_arready_out) else $error("rvalid held after take");
   chk_rd_unmapped: assert property (rd_take && s_axi_araddr_in > 8'h18 |=>
      s_axi_rresp_out == `AOC_RESP_SLVERR && s_axi_rdata_out == 32'h0)
      else $error("unmapped read not refused");
   cov_pin: cover property ($rose(first_alarm_line_out));
   cov_irq: cover property ($rose(irq_out));
   cov_unmapped: cover property (rd_take && s_axi_araddr_in > 8'h18);
endmodule
bind aoc_top aoc_top_monitor u_mon (.clock_in(clock_in), .rst_n_in(rst_n_in),
   .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
   .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
   .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
   .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
   .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
   .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
   .s_axi_rready_in(s_axi_rready_in), .reading_valid_in(reading_valid_in),
   .scan_start_in(scan_start_in), .first_alarm_line_out(first_alarm_line_out),
   .second_alarm_line_out(second_alarm_line_out), .third_alarm_line_out(third_alarm_line_out),
   .fourth_alarm_line_out(fourth_alarm_line_out), .irq_out(irq_out));

// ### tb/aoc_pin_watch.sv
// Purpose: Model of the equipment watching the alarm pins
// Assumes: Push-pull pins sampled on the system clock
// Notes: Drives nothing back; counts level changes only
module aoc_pin_watch (
   input wire logic clock_in, // Clock
   input wire logic [3:0] pins_in, // Alarm pins
   output logic [7:0] moves_out = 8'h00 // Changes seen
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] last_q = 4'h0;
   // Any edge of either polarity is an alarm event to the equipment
   always @(posedge clock_in) begin
      last_q <= pins_in;
      if (pins_in != last_q) begin
         moves_out <= moves_out + 8'h01;
      end
   end
endmodule

// ### tb/tb.sv
// Purpose: Self-checking bench for the alarm output controller
// Assumes: 10 MHz clock, response ready lines held high
// Notes: Expected pin levels follow from the mode and polarity set here
`include "aoc_map.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic rv = 1'b0, ra = 1'b0, scanning = 1'b0, scan_start = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, rch = 8'h00;
   logic [31:0] wdata = 32'h0, rd_d;
   logic [1:0] rd_r, wr_r;
   logic [7:0] m0;
   wire awready, wready, bvalid, arready, rvalid, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [3:0] pins;
   wire [7:0] moves;
   int error_cnt = 0;
   int samples_checked = 0;
   always #50 clk = ~clk;
   aoc_top u_dut (.clock_in(clk), .rst_n_in(rst_n), .s_axi_awaddr_in(awaddr),
      .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(1'b1),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(1'b1), .reading_valid_in(rv), .reading_chan_in(rch),
      .reading_alarm_in(ra), .scanning_in(scanning), .scan_start_in(scan_start),
      .first_alarm_line_out(pins[0]), .second_alarm_line_out(pins[1]),
      .third_alarm_line_out(pins[2]), .fourth_alarm_line_out(pins[3]), .irq_out(irq));
   aoc_pin_watch u_watch (.clock_in(clk), .pins_in(pins), .moves_out(moves));
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t ns: %s", $time, msg);
      end
   endtask
   task automatic test_done;
      $display("Errors %0d, checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Write with both channels offered together; waits for the response
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (n < 100) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            wr_r = bresp;
            n = 200;
         end else n++;
      end
      if (n < 200) check(32'h0, 32'h1, "write hang");
      repeat (2) @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      while (n < 100) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            rd_d = rdata;
            rd_r = rresp;
            n = 200;
         end else n++;
      end
      if (n < 200) check(32'h0, 32'h1, "read hang");
   endtask
   // One reading pulse, then time for the two-edge pin path
   task automatic rdg(input logic [7:0] c, input logic al);
      @(posedge clk);
      rv <= 1'b1;
      rch <= c;
      ra <= al;
      @(posedge clk);
      rv <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic scan_pulse;
      @(posedge clk);
      scan_start <= 1'b1;
      @(posedge clk);
      scan_start <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic t_reset;
      int n;
      check(32'(pins), 32'h0, "idle pins");
      rd(`AOC_OFF_CTRL);
      check(rd_d, 32'h0000_00F0, "ctrl reset");
      rd(8'h1C);
      check(32'(rd_r), 32'(`AOC_RESP_SLVERR), "unmapped read");
      wr(8'h20, 32'h0000_0001);
      check(32'(wr_r), 32'(`AOC_RESP_SLVERR), "unmapped write");
      n = 0;
      rd(`AOC_OFF_STAT);
      // Readings are ignored until the assignment sweep ends
      while (rd_d[`AOC_STAT_BUSY_BIT] !== 1'b0 && n < 100) begin
         rd(`AOC_OFF_STAT);
         n++;
      end
      check(rd_d & 32'h0000_0100, 32'h0, "init sweep ends");
   endtask
   task automatic t_default;
      rdg(8'hC8, 1'b1);
      check(32'(pins), 32'h0, "reading off scan");
      scanning <= 1'b1;
      rdg(8'hC8, 1'b1);
      check(32'(pins), 32'h1, "default line");
      rdg(8'hC8, 1'b0);
      check(32'(pins), 32'h0, "track drop");
   endtask
   task automatic t_or;
      wr(`AOC_OFF_ASSIGN, 32'h0001_0203);
      wr(`AOC_OFF_ASSIGN, 32'h0001_0209);
      rdg(8'h03, 1'b1);
      check(32'(pins), 32'h4, "routed line");
      rdg(8'h09, 1'b1);
      rdg(8'h03, 1'b0);
      check(32'(pins), 32'h4, "or of channels");
      rdg(8'h09, 1'b0);
      check(32'(pins), 32'h0, "all inside");
      wr(`AOC_OFF_ASSIGN, 32'h0000_0203);
      rdg(8'h03, 1'b1);
      check(32'(pins), 32'h0, "deleted channel");
      // Assignment list lookup: deleted entry reads disabled, kept one enabled
      wr(`AOC_OFF_QUERY, 32'h0000_0003);
      rd(`AOC_OFF_QUERY);
      check(rd_d, 32'h8000_0203, "deleted from list");
      wr(`AOC_OFF_QUERY, 32'h0000_0009);
      rd(`AOC_OFF_QUERY);
      check(rd_d, 32'h8001_0209, "kept in list");
   endtask
   task automatic t_latch;
      wr(`AOC_OFF_ASSIGN, 32'h0001_0107);
      wr(`AOC_OFF_CTRL, 32'h0000_00D2);
      check(32'(pins), 32'h2, "low active idle");
      m0 = moves;
      rdg(8'h07, 1'b1);
      check(32'(pins), 32'h0, "latched low");
      check(32'(moves), 32'(m0 + 8'h01), "one edge seen");
      rdg(8'h07, 1'b0);
      check(32'(pins), 32'h0, "latch holds");
      wr(`AOC_OFF_CMD, 32'h0000_0002);
      check(32'(pins), 32'h2, "manual clear");
      rd(`AOC_OFF_STAT);
      check(rd_d & 32'h0000_0022, 32'h0000_0020, "data kept");
      scan_pulse;
      rd(`AOC_OFF_STAT);
      check(rd_d & 32'h0000_0022, 32'h0, "data erased");
   endtask
   task automatic t_track;
      rdg(8'h09, 1'b1);
      check(32'(pins), 32'h6, "track raise");
      wr(`AOC_OFF_CMD, 32'h0000_0004);
      check(32'(pins), 32'h2, "track clear");
      rd(`AOC_OFF_STAT);
      check(rd_d & 32'h0000_0044, 32'h0000_0040, "track data kept");
      rdg(8'h09, 1'b1);
      scan_pulse;
      check(32'(pins), 32'h2, "scan drops pin");
      rd(`AOC_OFF_STAT);
      check(rd_d & 32'h0000_0044, 32'h0, "scan erases data");
      // Software scan start through the command register
      rdg(8'h09, 1'b1);
      check(32'(pins), 32'h6, "track again");
      wr(`AOC_OFF_CMD, 32'h0000_0010);
      check(32'(pins), 32'h2, "soft scan start");
   endtask
   task automatic t_irq;
      wr(`AOC_OFF_IRQ_STAT, 32'h0000_000F);
      wr(`AOC_OFF_ASSIGN, 32'h0001_0304);
      rdg(8'h04, 1'b1);
      check(32'(pins), 32'hA, "fourth line");
      check(32'(irq), 32'h0, "masked irq");
      rd(`AOC_OFF_IRQ_STAT);
      check(rd_d, 32'h0000_0008, "event bit");
      wr(`AOC_OFF_IRQ_MASK, 32'h0000_0008);
      check(32'(irq), 32'h1, "irq raised");
      wr(`AOC_OFF_IRQ_STAT, 32'h0000_0008);
      check(32'(irq), 32'h0, "irq cleared");
   endtask
   // Reset for six cycles, then the scenarios in order
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_default;
      t_or;
      t_latch;
      t_track;
      t_irq;
      test_done;
   end
   // Watchdog well past the several hundred cycles the run needs
   initial begin
      #2000000;
      error_cnt++;
      test_done;
   end
endmodule
